// ===== rtl/pbm_pin_ctrl.sv
/*
 * pbm_pin_ctrl: override combiner for one pad.
 * assumes override enables and values are settled in the same clock.
 */
`timescale 1ns/1ps
`default_nettype none
module pbm_pin_ctrl
    import pbm_pkg::*;
(
    input wire logic dir_i,          // direction register bit
    input wire logic out_i,          // output register bit
    input wire logic pu_off_i,       // global pull-up disable
    input wire logic sleep_i,        // controller asleep
    input wire logic pu_oe_i,        // pull-up override enable
    input wire logic pu_ov_i,        // pull-up override value
    input wire logic dir_oe_i,       // direction override enable
    input wire logic dir_ov_i,       // direction override value
    input wire logic val_oe_i,       // port value override enable
    input wire logic val_ov_i,       // port value override value
    input wire logic ie_oe_i,        // input enable override enable
    input wire logic ie_ov_i,        // input enable override value
    output logic drive_o,            // output driver enable
    output logic value_o,            // value seen by the driver
    output logic pullup_o,           // pull-up on
    output logic input_en_o          // digital input enabled
);
    // direction: override value wins over the register bit
    always_comb begin
        drive_o = dir_oe_i ? dir_ov_i : dir_i;
    end

    // value: override only matters while the driver is on
    always_comb begin
        value_o = out_i;
        if (val_oe_i && drive_o) begin
            value_o = val_ov_i;
        end
    end

    // pull-up: normal case is input, port bit set, not globally off
    always_comb begin
        if (pu_oe_i) begin
            pullup_o = pu_ov_i;
        end else begin
            pullup_o = ~drive_o & out_i & ~pu_off_i;
        end
    end

    // input enable: sleep turns it off unless overridden
    always_comb begin
        input_en_o = ie_oe_i ? ie_ov_i : ~sleep_i;
    end
endmodule
`default_nettype wire

// ===== rtl/pbm_pkg.sv
/*
 * pbm_pkg: constants for the port b alternate-function mux.
 * assumes one 100 mhz clock and an eight-pin port.
 */
package pbm_pkg;
    // port width
    localparam int PBM_PINS = 8;

    // pin positions of the alternate functions
    localparam int PBM_BIT_SS = 0;
    localparam int PBM_BIT_SCK = 1;
    localparam int PBM_BIT_MOSI = 2;
    localparam int PBM_BIT_MISO = 3;
    localparam int PBM_BIT_T0CMPA = 4;
    localparam int PBM_BIT_T1CMPA = 5;
    localparam int PBM_BIT_T1CMPB = 6;
    localparam int PBM_BIT_T2CMPA = 7;

    // pin-change source number of bit 0
    localparam int PBM_PCSRC_BASE = 8;

    // reset values of the synchroniser stages and the registered pad and peripheral outputs
    localparam logic [7:0] PBM_RST_PAD = 8'h00;
    localparam logic [7:0] PBM_RST_SYNC = 8'hff;
    localparam logic PBM_RST_BIT = 1'b0;
    localparam logic PBM_RST_SS = 1'b1;
endpackage

// ===== rtl/pbm_port_b_mux.sv
/*
 * pbm_port_b_mux: alternate-function override for an eight-pin port.
 * timers claim pads over the output register bits, spi also over the direction
 * bits, pin-change sources claim the input buffers over sleep. assumes
 * register bits and peripheral
 * signals come from logic on clock_i; pad inputs are asynchronous.
 */
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - bit 7 drives timer2 compare a when output
// - bit 6 drives timer1 compare b when output
// - bit 5 drives timer1 compare a when output
// - bit 4 drives timer0 compare a when output
// - spi master forces bit 3 to input
// - spi slave: bit 3 follows its direction bit
// - spi slave forces bit 2 to input
// - spi master: bit 2 follows its direction bit
// - bit 1 clock; slave forces it input
// - spi master: bit 1 follows its direction bit
// - spi slave forces bit 0 to input
// - slave spi active only while select low
// - spi master: bit 0 follows its direction bit
// - forced inputs keep pull-up from output bit
// - pins are pin-change sources 8 to 15
// - miso and mosi split by role
// - value override replaces output bit when driving
// - direction override replaces direction bit
// - pull-up override ignores other bits
// - input-enable override ignores sleep state
module pbm_port_b_mux
    import pbm_pkg::*;
(
    input wire logic clock_i,                       // system clock
    input wire logic rst_n_i,                       // async reset, low
    input wire logic [7:0] dir_bit_i,               // direction bits
    input wire logic [7:0] out_bit_i,               // output bits
    input wire logic global_pullup_disable_i,       // all pull-ups off
    input wire logic sleep_i,                       // controller asleep
    input wire logic serial_periph_enable_i,        // spi on
    input wire logic serial_master_select_i,        // spi master role
    input wire logic spi_master_out_i,              // mosi as master
    input wire logic spi_slave_out_i,               // miso as slave
    input wire logic sck_out_i,                     // clock as master
    input wire logic timer2_compare_a_en_i,         // compare enables
    input wire logic timer1_compare_b_en_i,
    input wire logic timer1_compare_a_en_i,
    input wire logic timer0_compare_a_en_i,
    input wire logic timer2_compare_a_out_i,        // compare outputs
    input wire logic timer1_compare_b_out_i,
    input wire logic timer1_compare_a_out_i,
    input wire logic timer0_compare_a_out_i,
    input wire logic [7:0] pin_change_mask_i,       // per-pin mask
    input wire logic pin_change_group1_enable_i,    // group enable
    input wire logic [7:0] pad_in_i,                // pad levels
    output logic [7:0] pad_out_o,                   // pad drive value
    output logic [7:0] pad_oe_o,                    // pad driver on
    output logic [7:0] pad_pullup_o,                // pad pull-up on
    output logic [7:0] pad_input_en_o,              // input buffer on
    output logic [7:0] port_pin_o,                  // filtered pin levels
    output logic spi_master_in_o,                   // miso into master
    output logic spi_slave_in_o,                    // mosi into slave
    output logic sck_in_o,                          // clock into slave
    output logic spi_ss_in_o,                       // select level
    output logic slave_select_active_o,             // slave selected
    output logic [7:0] pin_change_src_o,            // sources 8..15
    output logic [7:0] pin_change_event_o           // change pulses
);
    // spi role decode
    logic spi_master;       // enabled as master
    logic spi_slave;        // enabled as slave

    // per-pin override vectors
    logic [7:0] pu_oe;      // pull-up override enable
    logic [7:0] pu_ov;      // pull-up override value
    logic [7:0] dir_oe;     // direction override enable
    logic [7:0] dir_ov;     // direction override value
    logic [7:0] val_oe;     // value override enable
    logic [7:0] val_ov;     // value override value
    logic [7:0] ie_oe;      // input enable override enable
    logic [7:0] ie_ov;      // input enable override value

    // combined per-pin results
    logic [7:0] next_oe;    // driver enable
    logic [7:0] next_out;   // driver value
    logic [7:0] next_pu;    // pull-up
    logic [7:0] next_ie;    // input enable

    // input synchroniser stages
    logic [7:0] sync_a;     // first stage, read by sync_b only
    logic [7:0] sync_b;     // second stage
    logic [7:0] sync_c;     // third stage
    logic [7:0] stable;     // accepted pin level
    logic [7:0] gated_in;   // level after input enable
    logic [7:0] seen_in;    // last level for change detect

    // role decode; with the spi off neither role claims a pin
    assign spi_master = serial_periph_enable_i & serial_master_select_i;
    assign spi_slave = serial_periph_enable_i & ~serial_master_select_i;

    // pull-up overrides: spi pins claim it when forcing input,
    // but the output bit still steers it, gated by the global off
    always_comb begin
        pu_oe = 8'h00;
        pu_ov = 8'h00;
        pu_oe[PBM_BIT_MISO] = spi_master;
        pu_oe[PBM_BIT_MOSI] = spi_slave;
        pu_oe[PBM_BIT_SCK] = spi_slave;
        pu_oe[PBM_BIT_SS] = spi_slave;
        // each spi pin: port bit gated by global disable
        pu_ov[PBM_BIT_MISO] = out_bit_i[PBM_BIT_MISO]
            & ~global_pullup_disable_i;
        pu_ov[PBM_BIT_MOSI] = out_bit_i[PBM_BIT_MOSI]
            & ~global_pullup_disable_i;
        pu_ov[PBM_BIT_SCK] = out_bit_i[PBM_BIT_SCK]
            & ~global_pullup_disable_i;
        pu_ov[PBM_BIT_SS] = out_bit_i[PBM_BIT_SS]
            & ~global_pullup_disable_i;
    end

    // direction overrides: value is always zero, i.e. forced input;
    // the role that is not forced falls back to the direction bit
    always_comb begin
        dir_oe = 8'h00;
        dir_ov = 8'h00;
        // miso: input as master, own direction as slave
        dir_oe[PBM_BIT_MISO] = spi_master;
        // mosi: input as slave, own direction as master
        dir_oe[PBM_BIT_MOSI] = spi_slave;
        // sck: input as slave, own direction as master
        dir_oe[PBM_BIT_SCK] = spi_slave;
        // select: input as slave, own direction as master
        dir_oe[PBM_BIT_SS] = spi_slave;
    end

    // value overrides: timers on the upper half, spi outputs below;
    // the select pin never gets a value from the spi
    always_comb begin
        val_oe = 8'h00;
        val_ov = 8'h00;
        // compare outputs; only reach the pad when driving
        val_oe[PBM_BIT_T2CMPA] = timer2_compare_a_en_i;
        val_ov[PBM_BIT_T2CMPA] = timer2_compare_a_out_i;
        val_oe[PBM_BIT_T1CMPB] = timer1_compare_b_en_i;
        val_ov[PBM_BIT_T1CMPB] = timer1_compare_b_out_i;
        val_oe[PBM_BIT_T1CMPA] = timer1_compare_a_en_i;
        val_ov[PBM_BIT_T1CMPA] = timer1_compare_a_out_i;
        val_oe[PBM_BIT_T0CMPA] = timer0_compare_a_en_i;
        val_ov[PBM_BIT_T0CMPA] = timer0_compare_a_out_i;
        // miso carries the slave output
        val_oe[PBM_BIT_MISO] = spi_slave;
        val_ov[PBM_BIT_MISO] = spi_slave_out_i;
        // mosi carries the master output
        val_oe[PBM_BIT_MOSI] = spi_master;
        val_ov[PBM_BIT_MOSI] = spi_master_out_i;
        // sck carries the master clock
        val_oe[PBM_BIT_SCK] = spi_master;
        val_ov[PBM_BIT_SCK] = sck_out_i;
        // select stays on the output bit in every role
        val_oe[PBM_BIT_SS] = 1'b0;
    end

    // input enable: an armed pin-change source keeps the
    // buffer alive even in sleep, so it can wake the core
    always_comb begin
        ie_oe = pin_change_mask_i & {8{pin_change_group1_enable_i}};
        ie_ov = 8'hff;
    end

    // one combiner per pad
    for (genvar g = 0; g < PBM_PINS; g++) begin : g_pin
        pbm_pin_ctrl u_pin (
            .dir_i(dir_bit_i[g]),
            .out_i(out_bit_i[g]),
            .pu_off_i(global_pullup_disable_i),
            .sleep_i(sleep_i),
            .pu_oe_i(pu_oe[g]),
            .pu_ov_i(pu_ov[g]),
            .dir_oe_i(dir_oe[g]),
            .dir_ov_i(dir_ov[g]),
            .val_oe_i(val_oe[g]),
            .val_ov_i(val_ov[g]),
            .ie_oe_i(ie_oe[g]),
            .ie_ov_i(ie_ov[g]),
            .drive_o(next_oe[g]),
            .value_o(next_out[g]),
            .pullup_o(next_pu[g]),
            .input_en_o(next_ie[g])
        );
    end

    // pad controls registered: one cycle late, but glitch-free
    // while override enables and values switch together

    // driver enable; reset leaves every pad an input
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pad_oe_o <= PBM_RST_PAD;
        end else begin
            pad_oe_o <= next_oe;
        end
    end

    // driver value; only meaningful while the enable is high
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pad_out_o <= PBM_RST_PAD;
        end else begin
            pad_out_o <= next_out;
        end
    end

    // pull-up; off in reset so nothing is pulled before setup
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pad_pullup_o <= PBM_RST_PAD;
        end else begin
            pad_pullup_o <= next_pu;
        end
    end

    // input buffer enable; off in reset, so reads are zero
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pad_input_en_o <= PBM_RST_PAD;
        end else begin
            pad_input_en_o <= next_ie;
        end
    end

    // three-stage synchroniser for the asynchronous pad levels;
    // stages reset high, the idle level of a pulled-up line,
    // so release from reset shows no false change
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sync_a <= PBM_RST_SYNC;
            sync_b <= PBM_RST_SYNC;
            sync_c <= PBM_RST_SYNC;
        end else begin
            sync_a <= pad_in_i;
            sync_b <= sync_a;
            sync_c <= sync_b;
        end
    end

    // a level is accepted once stages two and three agree;
    // a one-cycle blip between them is dropped
    // limitation: a pin toggling every cycle is never accepted
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            stable <= PBM_RST_SYNC;
        end else begin
            for (int i = 0; i < PBM_PINS; i++) begin
                if (sync_b[i] == sync_c[i]) begin
                    stable[i] <= sync_c[i];
                end
            end
        end
    end

    // disabled input buffers read low, as a gated pad would
    assign gated_in = stable & pad_input_en_o;

    // port readback of the gated level
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            port_pin_o <= PBM_RST_PAD;
        end else begin
            port_pin_o <= gated_in;
        end
    end

    // pin-change sources 8..15 on bits 0..7; the gated level,
    // so a sleeping unarmed pin cannot raise a source
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pin_change_src_o <= PBM_RST_PAD;
        end else begin
            pin_change_src_o <= gated_in;
        end
    end

    // change pulses for armed sources; the interrupt core
    // downstream keeps the sticky flag
    // seen_in resets low, matching gated_in while buffers are off
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            seen_in <= PBM_RST_PAD;
            pin_change_event_o <= PBM_RST_PAD;
        end else begin
            seen_in <= gated_in;
            pin_change_event_o <= (gated_in ^ seen_in) & ie_oe;
        end
    end

    // peripheral inputs, split by role so neither side sees
    // its own outgoing data looped back

    // master data in from bit 3
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            spi_master_in_o <= PBM_RST_BIT;
        end else begin
            spi_master_in_o <= gated_in[PBM_BIT_MISO];
        end
    end

    // slave data in from bit 2
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            spi_slave_in_o <= PBM_RST_BIT;
        end else begin
            spi_slave_in_o <= gated_in[PBM_BIT_MOSI];
        end
    end

    // clock into the slave from bit 1
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sck_in_o <= PBM_RST_BIT;
        end else begin
            sck_in_o <= gated_in[PBM_BIT_SCK];
        end
    end

    // select level, ungated: a sleeping pin still reads the line;
    // resets high so the slave starts deselected
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            spi_ss_in_o <= PBM_RST_SS;
        end else begin
            spi_ss_in_o <= stable[PBM_BIT_SS];
        end
    end

    // slave selected only while enabled as slave and select low;
    // the external master owns the select line
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            slave_select_active_o <= PBM_RST_BIT;
        end else begin
            slave_select_active_o <= spi_slave & ~stable[PBM_BIT_SS];
        end
    end
endmodule
`default_nettype wire

// ===== testbench/pbm_pad_model.sv
/* pbm_pad_model: pads with external spi devices and loads.
   assumes level_o feeds the mux pad inputs straight back. */
`timescale 1ns/1ps
`default_nettype none
module pbm_pad_model (
    input wire logic clock_i,
    input wire logic [7:0] pad_out_i,
    input wire logic [7:0] pad_oe_i,
    input wire logic [7:0] pad_pullup_i,
    input wire logic [7:0] ext_en_i,
    input wire logic [7:0] ext_val_i,
    output logic [7:0] level_o
);
    logic [7:0] flt = 8'h00; // undriven pads without pull-up flip, never hold last level
    // device driver wins; external parts release while it drives
    always_comb begin
        level_o = (pad_oe_i & pad_out_i)
            | (~pad_oe_i & ext_en_i & ext_val_i)
            | (~pad_oe_i & ~ext_en_i & (pad_pullup_i | flt));
    end
    // floating pattern changes every cycle
    always @(posedge clock_i) begin
        flt <= ~level_o;
    end
endmodule
`default_nettype wire

// ===== testbench/pbm_port_b_monitor.sv
/* pbm_port_b_monitor: concurrent checks on the port b mux.
   assumes one clock, async low reset, pad outputs one cycle late. */
`timescale 1ns/1ps
`default_nettype none
module pbm_port_b_monitor (
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic [7:0] dir_bit_i,
    input wire logic [7:0] out_bit_i,
    input wire logic global_pullup_disable_i,
    input wire logic serial_periph_enable_i,
    input wire logic serial_master_select_i,
    input wire logic timer2_compare_a_en_i,
    input wire logic timer2_compare_a_out_i,
    input wire logic [7:0] pin_change_mask_i,
    input wire logic pin_change_group1_enable_i,
    input wire logic [7:0] pad_in_i,
    input wire logic [7:0] pad_out_o,
    input wire logic [7:0] pad_oe_o,
    input wire logic [7:0] pad_pullup_o,
    input wire logic [7:0] pad_input_en_o,
    input wire logic slave_select_active_o,
    input wire logic [7:0] pin_change_event_o
);
    // one domain, so clock and reset are given once
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);
    // spi role decodes
    wire spi_m = serial_periph_enable_i && serial_master_select_i;
    wire spi_s = serial_periph_enable_i && !serial_master_select_i;
    // select held long enough to pass the input filter
    sequence s_slave_low;
        (spi_s && !pad_in_i[0]) [*6];
    endsequence
    sequence s_slave_high;
        (spi_s && pad_in_i[0]) [*6];
    endsequence
    a_miso_master_in: assert property (spi_m |=> !pad_oe_o[3])
        else $error("miso driven in master role");
    a_miso_slave_dir: assert property (spi_s |=> pad_oe_o[3] == $past(dir_bit_i[3]))
        else $error("miso direction wrong in slave role");
    a_slave_forces_in: assert property (spi_s |=> pad_oe_o[2:0] == 3'h0)
        else $error("slave pin not forced to input");
    a_master_dir_follow: assert property (spi_m |=>
        pad_oe_o[2:0] == $past(dir_bit_i[2:0]))
        else $error("master pin direction wrong");
    a_timer_value_out: assert property (timer2_compare_a_en_i && dir_bit_i[7] |=>
        pad_oe_o[7] && pad_out_o[7] == $past(timer2_compare_a_out_i))
        else $error("compare value missing on bit 7");
    a_forced_pullup: assert property (spi_m |=>
        pad_pullup_o[3] == $past(out_bit_i[3] && !global_pullup_disable_i))
        else $error("forced input pull-up wrong");
    a_armed_input_on: assert property (pin_change_group1_enable_i |=>
        (pad_input_en_o & $past(pin_change_mask_i)) == $past(pin_change_mask_i))
        else $error("armed pin input buffer off");
    a_select_value_kept: assert property (dir_bit_i[0] && !spi_s |=>
        pad_out_o[0] == $past(out_bit_i[0]))
        else $error("select pin value overridden");
    a_slave_selected: assert property (s_slave_low |=> slave_select_active_o)
        else $error("slave not selected");
    a_slave_idle: assert property (s_slave_high |=> !slave_select_active_o)
        else $error("slave selected while select high");
    a_event_one_cycle: assert property (pin_change_event_o != 8'h00 |=>
        (pin_change_event_o & $past(pin_change_event_o)) == 8'h00)
        else $error("pin change event longer than a cycle");
endmodule
bind pbm_port_b_mux pbm_port_b_monitor mon (.*);
`default_nettype wire

// ===== testbench/tb_top.sv
/* tb_top: self-checking bench for the port b mux.
   assumes the pad model closes the loop and the monitor is bound. */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic clock_i, rst_n_i;
    logic [63:0] stim; // packed inputs, see calc for fields
    logic [7:0] pad_in, pad_out, pad_oe, pad_pu, pad_ie, port_pin, src, evt;
    logic mst_in, slv_in, sck_in, ss_in, ss_act;
    logic [7:0] e_oe, e_val, e_pu, e_ie, lvl, known, p_gated, p_known, p_ie, ev;
    int failures, num_checks, seed;
    int cycles = 0;
    pbm_port_b_mux DUT (.clock_i(clock_i), .rst_n_i(rst_n_i),
        .dir_bit_i(stim[7:0]), .out_bit_i(stim[15:8]),
        .global_pullup_disable_i(stim[16]), .sleep_i(stim[17]),
        .serial_periph_enable_i(stim[18]), .serial_master_select_i(stim[19]),
        .spi_master_out_i(stim[20]), .spi_slave_out_i(stim[21]), .sck_out_i(stim[22]),
        .timer0_compare_a_en_i(stim[23]), .timer1_compare_a_en_i(stim[24]),
        .timer1_compare_b_en_i(stim[25]), .timer2_compare_a_en_i(stim[26]),
        .timer0_compare_a_out_i(stim[27]), .timer1_compare_a_out_i(stim[28]),
        .timer1_compare_b_out_i(stim[29]), .timer2_compare_a_out_i(stim[30]),
        .pin_change_mask_i(stim[38:31]), .pin_change_group1_enable_i(stim[39]),
        .pad_in_i(pad_in), .pad_out_o(pad_out), .pad_oe_o(pad_oe),
        .pad_pullup_o(pad_pu), .pad_input_en_o(pad_ie), .port_pin_o(port_pin),
        .spi_master_in_o(mst_in), .spi_slave_in_o(slv_in), .sck_in_o(sck_in),
        .spi_ss_in_o(ss_in), .slave_select_active_o(ss_act),
        .pin_change_src_o(src), .pin_change_event_o(evt));
    pbm_pad_model pads (.clock_i(clock_i), .pad_out_i(pad_out), .pad_oe_i(pad_oe),
        .pad_pullup_i(pad_pu), .ext_en_i(stim[47:40]), .ext_val_i(stim[55:48]),
        .level_o(pad_in));
    // expected pad controls and settled levels for one stimulus word
    function automatic void calc(input logic [63:0] v);
        e_oe = v[7:0];
        e_val = v[15:8];
        if (v[18] && v[19]) begin // master role
            e_oe[3] = 1'b0;
            e_val[2] = v[20];
            e_val[1] = v[22];
        end
        if (v[18] && !v[19]) begin // slave role
            e_oe[2:0] = 3'h0;
            e_val[3] = v[21];
        end
        for (int k = 0; k < 4; k++) begin
            if (v[23+k]) e_val[4+k] = v[27+k];
        end
        e_pu = ~e_oe & v[15:8] & {8{!v[16]}};
        e_ie = {8{!v[17]}} | (v[38:31] & {8{v[39]}});
        known = e_oe | v[47:40] | e_pu; // floating pins are left out
        lvl = (e_oe & e_val) | (~e_oe & v[47:40] & v[55:48]) | (~e_oe & ~v[47:40]);
    endfunction
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic close_out;
        if (failures == 0 && num_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    // apply one word, check pads after one edge, inputs once filtered
    task automatic step(input logic [63:0] v);
        logic [7:0] g;
        logic [7:0] st;
        @(posedge clock_i);
        stim <= v;
        calc(v);
        ev = 8'h00;
        @(posedge clock_i);
        @(negedge clock_i);
        check(pad_oe, e_oe);
        check(pad_out & e_oe, e_val & e_oe);
        check(pad_pu, e_pu);
        check(pad_ie, e_ie);
        repeat (10) begin
            @(negedge clock_i);
            ev |= evt;
        end
        g = lvl & e_ie;
        check(port_pin & known, g & known);
        check(src & known, g & known);
        if (known[3]) check(mst_in, g[3]);
        if (known[2]) check(slv_in, g[2]);
        if (known[1]) check(sck_in, g[1]);
        if (known[0]) check(ss_in, lvl[0]);
        if (known[0]) check(ss_act, v[18] & !v[19] & !lvl[0]);
        // buffer-enable changes can pulse twice, so those pins are skipped
        st = known & p_known & ~(e_ie ^ p_ie);
        check(ev & st, (g ^ p_gated) & v[38:31] & {8{v[39]}} & st);
        p_gated = g;
        p_known = known;
        p_ie = e_ie;
    endtask
    // 100 mhz clock
    initial begin
        clock_i = 1'b0;
        forever #5 clock_i = ~clock_i;
    end
    // hang guard, well past the expected run length
    always @(posedge clock_i) begin
        cycles <= cycles + 1;
        if (cycles == 2000) begin
            failures++;
            close_out;
        end
    end
    // corner words first, then seeded random words
    initial begin
        seed = 29563;
        failures = 0;
        num_checks = 0;
        rst_n_i = 1'b0;
        stim = 64'h0;
        p_known = 8'h00;
        p_gated = 8'h00;
        p_ie = 8'h00;
        repeat (10) @(posedge clock_i);
        rst_n_i <= 1'b1;
        step(64'h0000_0000_001c_ffff); // master, all outputs
        step(64'h0000_0100_0024_ffff); // slave, select pulled low
        step(64'h0055_ffff_8002_0000); // asleep, all pins armed
        step(64'h00aa_ffff_8002_0000); // armed pins all change
        step(64'h0000_0000_5780_00ff); // all compare enables on, timer1 a and timer2 a outputs high
        repeat (60) step({$random(seed), $random(seed)});
        close_out;
    end
endmodule
`default_nettype wire
